// File: rcs_pkg.sv
// Package for the reset cause and release sequencer.
// Assumes a 100 MHz system clock and an AHB-Lite register port.
package rcs_pkg;

	localparam int CLK_MHZ = 100;

	// Register byte addresses
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_OSCCTL  = 8'h04;
	localparam logic [7:0] ADDR_CALIB   = 8'h08;
	localparam logic [7:0] ADDR_NVCTL   = 8'h0C;
	localparam logic [7:0] ADDR_SEQSTAT = 8'h10;

	// Status register bit positions
	localparam int B_TRAP  = 15;
	localparam int B_ILLOP = 14;
	localparam int B_CMIS  = 9;
	localparam int B_PMSLP = 8;
	localparam int B_PIN   = 7;
	localparam int B_SOFT  = 6;
	localparam int B_WDSEN = 5;
	localparam int B_WATCHDOG_TIMEOUT_FLAG  = 4;
	localparam int B_SLEEP = 3;
	localparam int B_IDLE  = 2;
	localparam int B_BROWN = 1;
	localparam int B_PON   = 0;
	localparam logic [15:0] STATUS_MASK = 16'hC3FF;
	localparam logic [15:0] STATUS_POR  = 16'h0003;

	// Oscillator control: current source field position
	localparam int OSC_CUR_LSB = 12;
	localparam logic [2:0] OSC_FRC = 3'h0;
	localparam logic [15:0] CALIB_POR = 16'h0000;
	localparam logic [15:0] NVCTL_POR = 16'h0000;

	// Source codes treated as crystal / PLL
	localparam logic [2:0] OSC_FRCPLL = 3'h1;
	localparam logic [2:0] OSC_XT     = 3'h2;
	localparam logic [2:0] OSC_XTPLL  = 3'h3;

	// Timing
	localparam int POR_DELAY_US   = 10;
	localparam int POWER_UP_TIMER_DELAY_MS  = 64;
	localparam int RST_DELAY_US   = 1;
	localparam int FAILSAFE_CLOCK_MONITOR_DELAY_US  = 100;
	localparam int POR_CYC   = POR_DELAY_US * CLK_MHZ;
	localparam int POWER_UP_TIMER_CYC  = POWER_UP_TIMER_DELAY_MS * 1000 * CLK_MHZ;
	localparam int RST_CYC   = RST_DELAY_US * CLK_MHZ;
	localparam int FAILSAFE_CLOCK_MONITOR_CYC  = FAILSAFE_CLOCK_MONITOR_DELAY_US * CLK_MHZ;
	localparam int OST_COUNT = 1024;

	typedef enum logic [2:0] {
		SQ_POR, SQ_POWER_UP_TIMER, SQ_RST, SQ_CLKWAIT, SQ_RUN
	} rcs_seq_t;

endpackage : rcs_pkg

// File: rcs_ost.sv
// Oscillator start-up counter with a 10-bit count of oscillator periods.
// Assumes osc_tick_i pulses once per oscillator period, synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module rcs_ost
	import rcs_pkg::*;
(
	input  wire logic clock_i,     // System clock
	input  wire logic rstn_i,      // Async reset, active low
	input  wire logic restart_i,   // Restart the count
	input  wire logic osc_tick_i,  // One oscillator period elapsed
	output logic      done_o       // Count of 1024 periods reached
);
	typedef struct packed {
		logic [9:0] cnt;
		logic       done;
	} rcs_ost_st_t;

	rcs_ost_st_t st, next_st;

	always_comb begin
		next_st = st;
		if (restart_i) begin
			next_st = '0;
		end else if (!st.done && osc_tick_i) begin
			next_st.cnt = st.cnt + 10'h001;
			if (st.cnt == 10'(OST_COUNT - 1))
				next_st.done = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign done_o = st.done;

endmodule : rcs_ost
`default_nettype wire

// File: rcs_seq.sv
// Reset cause recorder, clock source selection and reset release sequencer.
// Assumes event inputs are one-cycle pulses synchronous to clock_i, and
// rstn_i is the raw power-on reset.
`timescale 1ns/1ps
`default_nettype none
module rcs_seq
	import rcs_pkg::*;
#(
	parameter int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYC  // Shorten for simulation
)(
	input  wire logic        clock_i,          // 100 MHz system clock
	input  wire logic        rstn_i,           // Power-on reset, active low
	input  wire logic        hsel,             // AHB slave select
	input  wire logic [31:0] haddr,            // AHB address
	input  wire logic [1:0]  htrans,           // AHB transfer type
	input  wire logic        hwrite,           // AHB write
	input  wire logic [2:0]  hsize,            // AHB size
	input  wire logic [31:0] hwdata,           // AHB write data
	input  wire logic        hready,           // AHB bus ready
	output logic [31:0]      hrdata,           // AHB read data
	output logic             hreadyout,        // AHB slave ready
	output logic             hresp,            // AHB response
	input  wire logic        brownout_i,       // Brown-out reset pulse
	input  wire logic        pin_reset_i,      // Master clear pin reset pulse
	input  wire logic        soft_reset_i,     // Reset instruction pulse
	input  wire logic        wdt_timeout_i,    // Watchdog time-out pulse
	input  wire logic        trap_conflict_i,  // Trap conflict pulse
	input  wire logic        illegal_op_i,     // Illegal opcode pulse
	input  wire logic        cfg_mismatch_i,   // Config mismatch pulse
	input  wire logic        power_save_instruction_sleep_i,   // Sleep instruction pulse
	input  wire logic        power_save_instruction_idle_i,    // Idle instruction pulse
	input  wire logic        watchdog_fuse_enable_i, // Fuse, 1 = unprogrammed
	input  wire logic        clk_switch_en_i,  // Clock switching enabled
	input  wire logic [2:0]  new_osc_config_field_i, // Configured source
	input  wire logic        two_speed_i,      // Two-speed start-up enabled
	input  wire logic        failsafe_clock_monitor_en_i,        // Fail-safe monitor enabled
	input  wire logic        osc_tick_i,       // Primary oscillator period
	input  wire logic        pll_lock_i,       // PLL locked
	input  wire logic        frc_ready_i,      // Fast RC running
	input  wire logic        clock_valid_i,    // Monitor sees a clock
	output logic             master_system_reset_o, // Master reset, active high
	output logic             clock_released_o, // Clock released, code may run
	output logic [2:0]       clock_source_o,   // Selected source
	output logic             failsafe_clock_monitor_active_o,    // Monitor running
	output logic             osc_fail_trap_o,  // Oscillator failure trap
	output logic             watchdog_en_o     // Watchdog enabled
);

	typedef enum logic [1:0] {RT_POR, RT_BOR, RT_OTHER} rcs_rtype_t;

	typedef struct packed {
		rcs_seq_t    seq;
		rcs_rtype_t  rtype;
		logic [22:0] cnt;
		logic [13:0] fcnt;
		logic        fwait;
		logic        fact;
		logic        trap;
		logic [15:0] status;
		logic [2:0]  cur_osc;
		logic [15:0] calib;
		logic [15:0] nvctl;
		logic        ph_wr;
		logic        ph_rd;
		logic [7:0]  ph_addr;
		logic        pon;
		logic [31:0] rdata;
	} rcs_st_t;

	rcs_st_t st, next_st;
	logic    any_reset;
	logic    ost_restart;
	logic    ost_done;
	logic    xtal_src;
	logic    pll_src;
	logic    clk_ok;
	logic    pon_seen;

	function automatic logic is_pll(input logic [2:0] s);
		is_pll = (s == OSC_FRCPLL) || (s == OSC_XTPLL);
	endfunction : is_pll

	function automatic logic is_xtal(input logic [2:0] s);
		is_xtal = (s == OSC_XT) || (s == OSC_XTPLL);
	endfunction : is_xtal

	assign any_reset = brownout_i | pin_reset_i | soft_reset_i | wdt_timeout_i |
		trap_conflict_i | illegal_op_i | cfg_mismatch_i;
	assign xtal_src = is_xtal(st.cur_osc) && !two_speed_i;
	assign pll_src  = is_pll(st.cur_osc);
	// Start-up counter restarts with each reset, running beside the delays
	assign ost_restart = any_reset || !pon_seen;
	assign clk_ok = (two_speed_i ? frc_ready_i : (!xtal_src || ost_done)) &&
		(!pll_src || pll_lock_i);

	// Low through reset and the first cycle after power-on release, high from then on
	assign pon_seen = st.pon;

	rcs_ost u_ost (
		.clock_i    (clock_i),
		.rstn_i     (rstn_i),
		.restart_i  (ost_restart),
		.osc_tick_i (osc_tick_i),
		.done_o     (ost_done)
	);

	always_comb begin
		logic [15:0] hw_set;
		logic [15:0] hw_clr;
		logic [15:0] wv;
		hw_set = '0;
		hw_clr = '0;
		wv     = '0;
		next_st = st;

		// Hardware flag events
		hw_set[B_TRAP]  = trap_conflict_i;
		hw_set[B_ILLOP] = illegal_op_i;
		hw_set[B_CMIS]  = cfg_mismatch_i;
		hw_set[B_PIN]   = pin_reset_i;
		hw_set[B_SOFT]  = soft_reset_i;
		hw_set[B_WATCHDOG_TIMEOUT_FLAG]  = wdt_timeout_i;
		hw_set[B_BROWN] = brownout_i;
		hw_set[B_SLEEP] = power_save_instruction_sleep_i;
		hw_set[B_IDLE]  = power_save_instruction_idle_i;
		hw_clr[B_WATCHDOG_TIMEOUT_FLAG]  = power_save_instruction_sleep_i | power_save_instruction_idle_i;

		// AHB data phase
		if (st.ph_wr) begin
			wv = hwdata[15:0] & STATUS_MASK;
			case (st.ph_addr)
				ADDR_STATUS: next_st.status = wv;
				ADDR_OSCCTL: next_st.cur_osc = hwdata[OSC_CUR_LSB +: 3];
				ADDR_CALIB:  next_st.calib = hwdata[15:0];
				ADDR_NVCTL:  next_st.nvctl = hwdata[15:0];
				default: ;
			endcase
		end
		// Hardware set wins over software write in the same cycle
		next_st.status = (next_st.status & ~hw_clr) | hw_set;

		next_st.ph_wr = 1'b0;
		next_st.ph_rd = 1'b0;
		if (hsel && hready && htrans[1]) begin
			next_st.ph_wr   = hwrite;
			next_st.ph_rd   = !hwrite;
			next_st.ph_addr = haddr[7:0];
			case (haddr[7:0])
				ADDR_STATUS:  next_st.rdata = {16'h0000, st.status};
				ADDR_OSCCTL:  next_st.rdata = {17'h00000, st.cur_osc, 12'h000};
				ADDR_CALIB:   next_st.rdata = {16'h0000, st.calib};
				ADDR_NVCTL:   next_st.rdata = {16'h0000, st.nvctl};
				ADDR_SEQSTAT: next_st.rdata = {26'h0000000, st.trap, st.fact,
					clk_ok, st.seq == SQ_RUN, 2'(st.rtype)};
				default:      next_st.rdata = 32'h00000000;
			endcase
		end

		// Reset release sequence
		if (st.cnt != '0)
			next_st.cnt = st.cnt - 23'h000001;
		case (st.seq)
			SQ_POR: if (st.cnt == '0) begin
				next_st.seq = SQ_POWER_UP_TIMER;
				next_st.cnt = 23'(POWER_UP_TIMER_CYCLES - 1);
			end
			SQ_POWER_UP_TIMER: if (st.cnt == '0) begin
				next_st.seq = SQ_RST;
				next_st.cnt = 23'(RST_CYC - 1);
				// Monitor delay follows power-on and power-up delays
				next_st.fwait = pll_src || xtal_src;
				next_st.fcnt  = 14'(FAILSAFE_CLOCK_MONITOR_CYC - 1);
			end
			SQ_RST: if (st.cnt == '0)
				next_st.seq = SQ_CLKWAIT;
			SQ_CLKWAIT: if (clk_ok || st.fact)
				next_st.seq = SQ_RUN;
			SQ_RUN: ;
			default: next_st.seq = SQ_POR;
		endcase

		// Fail-safe monitor start
		if (st.fwait) begin
			if (st.fcnt == '0)
				next_st.fwait = 1'b0;
			else
				next_st.fcnt = st.fcnt - 14'h0001;
		end
		if (failsafe_clock_monitor_en_i && !st.fact && !st.fwait && !next_st.fwait &&
			!master_system_reset_o) begin
			next_st.fact = 1'b1;
			if (!clk_ok) begin
				next_st.trap    = 1'b1;
				next_st.cur_osc = OSC_FRC;
			end
		end

		// Warm resets: only the internal-state delay, brown-out adds power-up
		if (any_reset) begin
			next_st.fact  = 1'b0;
			next_st.fwait = 1'b0;
			next_st.trap  = 1'b0;
			if (brownout_i) begin
				next_st.rtype = RT_BOR;
				next_st.seq   = SQ_POWER_UP_TIMER;
				next_st.cnt   = 23'(POWER_UP_TIMER_CYCLES - 1);
			end else begin
				next_st.rtype = RT_OTHER;
				next_st.seq   = SQ_RST;
				next_st.cnt   = 23'(RST_CYC - 1);
			end
			if (!clk_switch_en_i || brownout_i)
				next_st.cur_osc = new_osc_config_field_i;
			if (two_speed_i)
				next_st.cur_osc = OSC_FRC;
		end

		// Source at power-on is caught after release, never under reset
		next_st.pon = 1'b1;
		if (!st.pon)
			next_st.cur_osc = two_speed_i ? OSC_FRC : new_osc_config_field_i;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= '0;
			st.seq    <= SQ_POR;
			st.rtype  <= RT_POR;
			st.cnt    <= 23'(POR_CYC - 1);
			st.status <= STATUS_POR;
			st.calib  <= CALIB_POR;
			st.nvctl  <= NVCTL_POR;
		end else begin
			st <= next_st;
		end
	end

	assign master_system_reset_o = (st.seq == SQ_POR) || (st.seq == SQ_POWER_UP_TIMER) ||
		(st.seq == SQ_RST) || !pon_seen;
	assign clock_released_o = st.seq == SQ_RUN;
	assign clock_source_o   = st.cur_osc;
	assign failsafe_clock_monitor_active_o    = st.fact;
	assign osc_fail_trap_o  = st.trap;
	assign watchdog_en_o    = watchdog_fuse_enable_i | st.status[B_WDSEN];
	assign hrdata    = st.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	a_brown_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
		brownout_i |=> st.status[B_BROWN])
		else $error("brown-out flag not set");
	a_flag_hw_win: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(pin_reset_i && st.ph_wr) |=> st.status[B_PIN])
		else $error("hardware set lost to write");
	a_watchdog_timeout_flag_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(power_save_instruction_idle_i && !wdt_timeout_i) |=> !st.status[B_WATCHDOG_TIMEOUT_FLAG])
		else $error("watchdog flag not cleared");
	a_wdt_fuse: assert property (@(posedge clock_i) disable iff (!rstn_i)
		watchdog_fuse_enable_i |-> watchdog_en_o)
		else $error("watchdog disabled with fuse set");
	a_rst_assert: assert property (@(posedge clock_i) disable iff (!rstn_i)
		any_reset |=> master_system_reset_o)
		else $error("reset source did not assert master reset");
	a_warm_delay: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(soft_reset_i && !brownout_i) |=> master_system_reset_o [*8])
		else $error("internal state delay too short");
	a_no_run: assert property (@(posedge clock_i) disable iff (!rstn_i)
		master_system_reset_o |-> !clock_released_o)
		else $error("code released during reset");
	a_failsafe_clock_monitor_trap: assert property (@(posedge clock_i) disable iff (!rstn_i)
		($rose(st.fact) && !$past(clk_ok)) |-> st.trap && st.cur_osc == OSC_FRC)
		else $error("monitor missed failure");
	a_pon_sticky: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(st.status[B_PON] && !st.ph_wr) |=> st.status[B_PON])
		else $error("power-on flag cleared by hardware");

endmodule : rcs_seq
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the reset cause and release sequencer.
// Assumes hreadyout is the bus hready and reads answer in the data phase.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rcs_pkg::*;
	// Short power-up delay keeps the run brief; expectations follow from it
	localparam int PW = 50;
	logic        clock_i;
	logic        rstn_i;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [2:0]  cfg;
	logic [2:0]  clock_source_o;
	logic [8:0]  evt;
	logic        fuse;
	logic        sw_en;
	logic        failsafe_clock_monitor_en;
	logic        tick;
	logic        msr;
	logic        rel;
	logic        wd_en;
	logic        tspd;
	logic        trap_o;
	logic        exp_trap;
	int          err_total;
	int          n_tests;
	int          n;
	int          k;
	logic [15:0] exp_st;
	logic [2:0]  exp_src;
	int          bpos [9] = '{B_BROWN, B_PIN, B_SOFT, B_WATCHDOG_TIMEOUT_FLAG, B_TRAP, B_ILLOP, B_CMIS,
	                          B_SLEEP, B_IDLE};

	assign hready = hreadyout;

	rcs_seq #(.POWER_UP_TIMER_CYCLES(PW)) dut_u (
		.clock_i(clock_i), .rstn_i(rstn_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .brownout_i(evt[0]), .pin_reset_i(evt[1]),
		.soft_reset_i(evt[2]), .wdt_timeout_i(evt[3]), .trap_conflict_i(evt[4]),
		.illegal_op_i(evt[5]), .cfg_mismatch_i(evt[6]), .power_save_instruction_sleep_i(evt[7]),
		.power_save_instruction_idle_i(evt[8]), .watchdog_fuse_enable_i(fuse), .clk_switch_en_i(sw_en),
		.new_osc_config_field_i(cfg), .two_speed_i(tspd), .failsafe_clock_monitor_en_i(failsafe_clock_monitor_en),
		.osc_tick_i(tick), .pll_lock_i(1'b1), .frc_ready_i(1'b1), .clock_valid_i(1'b1),
		.master_system_reset_o(msr), .clock_released_o(rel),
		.clock_source_o(clock_source_o), .failsafe_clock_monitor_active_o(), .osc_fail_trap_o(trap_o),
		.watchdog_en_o(wd_en)
	);

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// One oscillator period every two system cycles
	always @(posedge clock_i) begin
		tick <= ~tick;
	end

	task automatic give_verdict();
		$display("Comparisons %0d, errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			err_total++;
			$display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_rng

	task automatic hang(input string nm);
		err_total++;
		$display("Error %s expected completion seen timeout", nm);
		give_verdict();
	endtask : hang

	task automatic wait_ready();
		int c;
		c = 0;
		do begin
			@(posedge clock_i);
			c++;
		end while (hready !== 1'b1 && c < 50);
		if (c >= 50)
			hang("bus ready");
	endtask : wait_ready

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
	                   output logic [31:0] r);
		@(posedge clock_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		hsize <= 3'h2;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_ready();
		r = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h00000000, r);
		chk(nm, {16'h0000, e}, r);
		chk("response", 32'h0, {31'h0, hresp});
	endtask : rdc

	// Counts cycles until the master reset drops, then until the clock is released
	task automatic wait_rel(input int lo, input int hi);
		n = 0;
		while (msr === 1'b1 && n < 20000) begin
			@(posedge clock_i);
			n++;
		end
		if (n >= 20000)
			hang("master reset release");
		chk_rng("master reset hold", lo, hi, n);
		k = 0;
		while (rel !== 1'b1 && k < 5000) begin
			@(posedge clock_i);
			k++;
		end
		if (k >= 5000)
			hang("clock release");
		chk("clock source", {29'h0, exp_src}, {29'h0, clock_source_o});
	endtask : wait_rel

	task automatic fire(input int e);
		@(posedge clock_i);
		evt <= 9'h001 << e;
		@(posedge clock_i);
		evt <= 9'h000;
		#1;
		exp_st[bpos[e]] = 1'b1;
		if (e > 6)
			exp_st[B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		if (e < 7) begin
			chk("master reset", 32'h1, {31'h0, msr});
			chk("early release", 32'h0, {31'h0, rel});
			if (e == 0 || !sw_en)
				exp_src = cfg;
			if (tspd)
				exp_src = OSC_FRC;
			// Warm resets other than brown-out get no monitor delay, so a crystal still counting is a failure
			exp_trap = e != 0 && failsafe_clock_monitor_en && !tspd && (exp_src == OSC_XT || exp_src == OSC_XTPLL);
			if (exp_trap)
				exp_src = OSC_FRC;
			if (e == 0)
				wait_rel(RST_CYC + PW - 2, RST_CYC + PW + 4);
			else
				wait_rel(RST_CYC - 2, RST_CYC + 4);
			chk("fail trap", {31'h0, exp_trap}, {31'h0, trap_o});
		end
		rdc("status", ADDR_STATUS, exp_st);
	endtask : fire

	initial begin
		rstn_i = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		evt = 9'h000;
		fuse = 1'b0;
		tspd = 1'b0;
		sw_en = 1'b1;
		failsafe_clock_monitor_en = 1'b0;
		tick = 1'b0;
		cfg = OSC_XT;
		err_total = 0;
		n_tests = 0;
		k = $urandom(32'h796E);
		repeat (5) @(posedge clock_i);
		chk("reset out", 32'h1, {31'h0, msr});
		rstn_i <= 1'b1;
		exp_src = OSC_XT;
		wait_rel(POR_CYC + PW + RST_CYC - 2, POR_CYC + PW + RST_CYC + 6);
		// Start-up count overlaps the delay, so release is set by the count alone
		chk_rng("start-up overlap", 2 * OST_COUNT - 8, 2 * OST_COUNT + 40, n + k);
		exp_st = STATUS_POR;
		rdc("status", ADDR_STATUS, exp_st);
		for (int i = 0; i < 24; i++) begin
			k = $urandom_range(8);
			cfg <= 3'($urandom_range(3));
			sw_en <= 1'($urandom_range(1));
			failsafe_clock_monitor_en <= 1'($urandom_range(1));
			fire(k);
		end
		for (int i = 0; i < 8; i++) begin
			exp_st = (i == 0) ? 16'h0000 : 16'($urandom) & STATUS_MASK;
			fuse <= 1'($urandom_range(1));
			wr(ADDR_STATUS, {16'h0000, exp_st});
			repeat (2) @(posedge clock_i);
			chk("reset on write", 32'h0, {31'h0, msr});
			chk("watchdog enable", {31'h0, fuse | exp_st[B_WDSEN]}, {31'h0, wd_en});
			rdc("status", ADDR_STATUS, exp_st);
		end
		fire(0);
		wr(ADDR_CALIB, 32'h0000A5C3);
		wr(ADDR_NVCTL, 32'h00003C5A);
		wr(8'h20, 32'hFFFFFFFF);
		rdc("unmapped", 8'h20, 16'h0000);
		tspd <= 1'b1;
		fire(2);
		tspd <= 1'b0;
		fire(1);
		rdc("calibration kept", ADDR_CALIB, 16'hA5C3);
		rdc("nonvolatile kept", ADDR_NVCTL, 16'h3C5A);
		// Second power-on in mid-run
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rstn_i <= 1'b1;
		exp_src = cfg;
		wait_rel(POR_CYC + PW + RST_CYC - 2, POR_CYC + PW + RST_CYC + 6);
		rdc("status", ADDR_STATUS, STATUS_POR);
		rdc("calibration", ADDR_CALIB, CALIB_POR);
		rdc("nonvolatile", ADDR_NVCTL, NVCTL_POR);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
